// >>> core/iacc_map.svh
// register offsets, field positions, reset values and timing counts of the accept block
`ifndef IACC_MAP_SVH
`define IACC_MAP_SVH
// ***************************************************************
// register offsets (byte addresses)
// ***************************************************************
`define IACC_OFF_PEND 8'h00
`define IACC_OFF_LEVEL 8'h04
`define IACC_OFF_USP 8'h08
`define IACC_OFF_ISP 8'h0C
`define IACC_OFF_PORT8 8'h10
`define IACC_OFF_CM1 8'h14
`define IACC_OFF_EVT 8'h18
`define IACC_OFF_MASK 8'h1C
// ***************************************************************
// field positions
// ***************************************************************
`define IACC_P8_NMI_BIT 5
`define IACC_CM1_STOP_BIT 0
`define IACC_EVT_NMI 0
`define IACC_EVT_ACCEPT 1
`define IACC_EVT_PROG 2
`define IACC_INFO_LVL_LSB 4
// ***************************************************************
// reset values
// ***************************************************************
`define IACC_SP_RESET 16'h0000
`define IACC_LEVEL_RESET 24'h000000
// ***************************************************************
// timing: nmi low or high phase, 2 clocks plus 300 ns at 25 ns
// ***************************************************************
`define IACC_CLK_NS 25
`define IACC_NMI_EXTRA_NS 300
`define IACC_NMI_MIN_CLKS 2
`define IACC_NMI_MIN_CYC (`IACC_NMI_MIN_CLKS + (`IACC_NMI_EXTRA_NS + `IACC_CLK_NS - 1) / `IACC_CLK_NS)
`endif

// >>> core/iacc_pkg.sv
// types shared by the accept block and its arbiter
package iacc_pkg;
    typedef logic [2:0] iacc_level_t;
    typedef logic [15:0] iacc_sp_t;
    typedef logic [7:0] iacc_info_t;
    typedef logic [2:0] iacc_evt_t;
endpackage

// >>> core/iacc_arb_if.sv
// carrier between the accept block and its priority arbiter
interface iacc_arb_if #(parameter int N = 8, parameter int NW = 3);
    logic [N-1:0] pend;
    logic [N*3-1:0] level;
    logic sel_valid;
    logic [NW-1:0] sel_num;
    logic [2:0] sel_level;
    modport ctl (output pend, output level, input sel_valid, input sel_num, input sel_level);
    modport arb (input pend, input level, output sel_valid, output sel_num, output sel_level);
endinterface

// >>> core/iacc_arbiter.sv
// priority arbiter: picks the enabled pending source with the highest level
module iacc_arbiter #(
    parameter int N = 8,
    parameter int NW = 3
) (
    iacc_arb_if.arb arb
);
    import iacc_pkg::*;

    // level zero means disabled; on equal levels the lower number wins
    always_comb begin
        logic found;
        logic [NW-1:0] num;
        logic [2:0] lvl;
        found = 1'b0;
        num = '0;
        lvl = 3'h0;
        for (int i = 0; i < N; i++) begin
            if (arb.pend[i] && (arb.level[i*3 +: 3] > lvl)) begin
                found = 1'b1;
                num = NW'(i);
                lvl = arb.level[i*3 +: 3];
            end
        end
        arb.sel_valid = found;
        arb.sel_num = num;
        arb.sel_level = lvl;
    end
endmodule // iacc_arbiter

// >>> core/iacc_top.sv
// interrupt accept and nmi logic with its apb register slave
//
// Our own choices: the address map and the APB slave port.
`include "iacc_map.svh"
module iacc_top #(
    parameter int N = 8,
    parameter int NW = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [N-1:0] src_req,
    input wire logic nmi_pin_n,
    input wire logic cpu_instr_done,
    input wire logic cpu_info_rd,
    input wire logic cpu_prog_rd,
    input wire logic cpu_nmi_ack,
    input wire logic cpu_wait_mode,
    output logic cpu_irq_req,
    output logic cpu_nmi_req,
    output iacc_pkg::iacc_info_t cpu_info_data,
    output logic cpu_halt,
    output logic stop_mode_req,
    output iacc_pkg::iacc_sp_t user_stack_pointer,
    output iacc_pkg::iacc_sp_t interrupt_stack_pointer,
    output logic irq
);
    import iacc_pkg::*;

    // ***************************************************************
    // apb decode
    // ***************************************************************
    logic wr;
    logic setup;
    logic hit;
    assign wr = psel && penable && pwrite;
    assign setup = psel && !penable;
    assign hit = (paddr == `IACC_OFF_PEND) || (paddr == `IACC_OFF_LEVEL) ||
                 (paddr == `IACC_OFF_USP) || (paddr == `IACC_OFF_ISP) ||
                 (paddr == `IACC_OFF_PORT8) || (paddr == `IACC_OFF_CM1) ||
                 (paddr == `IACC_OFF_EVT) || (paddr == `IACC_OFF_MASK);
    // zero wait states; unmapped addresses end with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    // ***************************************************************
    // nmi pin synchroniser and level filter
    // ***************************************************************
    logic nmi_s1, nmi_s2, nmi_s3, nmi_lvl;
    logic next_nmi_lvl;
    logic nmi_fall;
    // the level only moves once two late stages agree; the pin holds each
    // phase far longer than this, so no edge is missed
    always_comb begin
        next_nmi_lvl = (nmi_s2 == nmi_s3) ? nmi_s3 : nmi_lvl;
    end
    assign nmi_fall = nmi_lvl && !next_nmi_lvl;
    // stage one feeds only stage two
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_s1 <= 1'b1;
            nmi_s2 <= 1'b1;
            nmi_s3 <= 1'b1;
            nmi_lvl <= 1'b1;
        end else begin
            nmi_s1 <= nmi_pin_n;
            nmi_s2 <= nmi_s1;
            nmi_s3 <= nmi_s2;
            nmi_lvl <= next_nmi_lvl;
        end
    end

    // ***************************************************************
    // pending flags and arbiter
    // ***************************************************************
    iacc_arb_if #(.N(N), .NW(NW)) arb_if ();
    iacc_arbiter #(.N(N), .NW(NW)) u_arb (.arb(arb_if.arb));

    logic [N-1:0] pend;
    logic [N-1:0] next_pend;
    logic [N*3-1:0] level;
    logic info_rd;
    assign info_rd = cpu_info_rd || cpu_prog_rd;
    assign arb_if.pend = pend;
    assign arb_if.level = level;

    // a new request wins over a clear in the same cycle
    generate
        for (genvar i = 0; i < N; i++) begin : g_src
            logic acc_clr;
            logic sw_clr;
            assign acc_clr = info_rd && arb_if.sel_valid && (arb_if.sel_num == NW'(i));
            assign sw_clr = wr && (paddr == `IACC_OFF_PEND) && pwdata[i];
            assign next_pend[i] = src_req[i] ? 1'b1 :
                                  ((acc_clr || sw_clr) ? 1'b0 : pend[i]);
        end
    endgenerate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend <= '0;
        end else begin
            pend <= next_pend;
        end
    end

    // ***************************************************************
    // interrupt information word
    // ***************************************************************
    iacc_info_t next_info;
    // ordinary program reads take the same path, so they also clear a flag
    always_comb begin
        next_info = cpu_info_data;
        if (info_rd) begin
            next_info = '0;
            if (arb_if.sel_valid) begin
                next_info[NW-1:0] = arb_if.sel_num;
                next_info[`IACC_INFO_LVL_LSB +: 3] = arb_if.sel_level;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_info_data <= '0;
        end else begin
            cpu_info_data <= next_info;
        end
    end

    // ***************************************************************
    // first instruction guard, nmi request, wait halt
    // ***************************************************************
    logic first_done, nmi_pend;
    logic next_first_done, next_nmi_pend, next_halt;
    always_comb begin
        next_first_done = first_done || cpu_instr_done;
        // no enable bit exists here, the edge always latches
        next_nmi_pend = nmi_fall ? 1'b1 : (cpu_nmi_ack ? 1'b0 : nmi_pend);
        // nmi falling in wait stalls the cpu; it leaves on a later interrupt request
        if (nmi_fall && cpu_wait_mode) begin
            next_halt = 1'b1;
        end else if (cpu_irq_req) begin
            next_halt = 1'b0;
        end else begin
            next_halt = cpu_halt;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_done <= 1'b0;
            nmi_pend <= 1'b0;
            cpu_halt <= 1'b0;
        end else begin
            first_done <= next_first_done;
            nmi_pend <= next_nmi_pend;
            cpu_halt <= next_halt;
        end
    end
    // both requests stay quiet until the first instruction retires
    assign cpu_irq_req = first_done && arb_if.sel_valid;
    assign cpu_nmi_req = first_done && nmi_pend;

    // ***************************************************************
    // software registers
    // ***************************************************************
    iacc_sp_t next_usp, next_isp;
    logic [N*3-1:0] next_level;
    logic next_stop;
    iacc_evt_t evt, mask, next_evt, next_mask;
    always_comb begin
        next_usp = user_stack_pointer;
        next_isp = interrupt_stack_pointer;
        next_level = level;
        next_mask = mask;
        next_stop = stop_mode_req;
        if (wr && paddr == `IACC_OFF_USP) begin
            next_usp = pwdata[15:0];
        end
        if (wr && paddr == `IACC_OFF_ISP) begin
            next_isp = pwdata[15:0];
        end
        if (wr && paddr == `IACC_OFF_LEVEL) begin
            next_level = pwdata[N*3-1:0];
        end
        if (wr && paddr == `IACC_OFF_MASK) begin
            next_mask = pwdata[2:0];
        end
        if (wr && paddr == `IACC_OFF_CM1) begin
            next_stop = pwdata[`IACC_CM1_STOP_BIT];
        end
        // a low nmi pins the stop request at zero, writes included
        if (!nmi_lvl) begin
            next_stop = 1'b0;
        end
        // sticky events: write one clears, a fresh event wins
        next_evt = evt;
        if (wr && paddr == `IACC_OFF_EVT) begin
            next_evt = evt & ~pwdata[2:0];
        end
        next_evt[`IACC_EVT_NMI] = next_evt[`IACC_EVT_NMI] | nmi_fall;
        next_evt[`IACC_EVT_ACCEPT] = next_evt[`IACC_EVT_ACCEPT] | cpu_info_rd;
        next_evt[`IACC_EVT_PROG] = next_evt[`IACC_EVT_PROG] | cpu_prog_rd;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            user_stack_pointer <= `IACC_SP_RESET;
            interrupt_stack_pointer <= `IACC_SP_RESET;
            level <= `IACC_LEVEL_RESET;
            mask <= '0;
            evt <= '0;
            stop_mode_req <= 1'b0;
        end else begin
            user_stack_pointer <= next_usp;
            interrupt_stack_pointer <= next_isp;
            level <= next_level;
            mask <= next_mask;
            evt <= next_evt;
            stop_mode_req <= next_stop;
        end
    end
    assign irq = |(evt & mask);

    // ***************************************************************
    // read data, captured in the setup cycle
    // ***************************************************************
    logic [31:0] next_prdata;
    always_comb begin
        next_prdata = prdata;
        if (setup) begin
            next_prdata = '0;
            case (paddr)
                `IACC_OFF_PEND: next_prdata[N-1:0] = pend;
                `IACC_OFF_LEVEL: next_prdata[N*3-1:0] = level;
                `IACC_OFF_USP: next_prdata[15:0] = user_stack_pointer;
                `IACC_OFF_ISP: next_prdata[15:0] = interrupt_stack_pointer;
                `IACC_OFF_PORT8: next_prdata[`IACC_P8_NMI_BIT] = nmi_lvl;
                `IACC_OFF_CM1: next_prdata[`IACC_CM1_STOP_BIT] = stop_mode_req;
                `IACC_OFF_EVT: next_prdata[2:0] = evt;
                `IACC_OFF_MASK: next_prdata[2:0] = mask;
                default: next_prdata = '0;
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else begin
            prdata <= next_prdata;
        end
    end

    // ***************************************************************
    // assertions
    // ***************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_info_word;
        info_rd && arb_if.sel_valid |=>
            cpu_info_data == {1'b0, $past(arb_if.sel_level), 1'b0, $past(arb_if.sel_num)};
    endproperty
    a_info_word: assert property (p_info_word) else $error("info word wrong");

    property p_accept_clears;
        cpu_info_rd && arb_if.sel_valid && !src_req[arb_if.sel_num] |=>
            !pend[$past(arb_if.sel_num)];
    endproperty
    a_accept_clears: assert property (p_accept_clears) else $error("flag kept");

    property p_prog_read;
        cpu_prog_rd && arb_if.sel_valid && !src_req[arb_if.sel_num] |=>
            !pend[$past(arb_if.sel_num)] && evt[`IACC_EVT_PROG];
    endproperty
    a_prog_read: assert property (p_prog_read) else $error("program read");

    property p_sp_reset;
        disable iff (1'b0) $rose(presetn) |->
            user_stack_pointer == 16'h0000 && interrupt_stack_pointer == 16'h0000;
    endproperty
    a_sp_reset: assert property (p_sp_reset) else $error("sp not zero");

    property p_first_instr;
        !first_done |-> !cpu_irq_req && !cpu_nmi_req;
    endproperty
    a_first_instr: assert property (p_first_instr) else $error("early request");

    property p_nmi_serviced;
        nmi_fall && first_done && !cpu_nmi_ack |=> cpu_nmi_req;
    endproperty
    a_nmi_serviced: assert property (p_nmi_serviced) else $error("nmi lost");

    property p_port8;
        setup && paddr == `IACC_OFF_PORT8 |=> prdata[`IACC_P8_NMI_BIT] == $past(nmi_lvl);
    endproperty
    a_port8: assert property (p_port8) else $error("port bit wrong");

    property p_stop_forced;
        !nmi_lvl |=> !stop_mode_req;
    endproperty
    a_stop_forced: assert property (p_stop_forced) else $error("stop while nmi low");

    property p_wait_halt;
        nmi_fall && cpu_wait_mode |=> cpu_halt;
    endproperty
    a_wait_halt: assert property (p_wait_halt) else $error("no halt");

    property p_src_set;
        src_req != '0 |=> (pend & $past(src_req)) == $past(src_req);
    endproperty
    a_src_set: assert property (p_src_set) else $error("request lost");

    c_accept: cover property (cpu_info_rd && arb_if.sel_valid ##1 cpu_irq_req == 1'b0);
    c_nmi: cover property (nmi_fall ##[1:20] cpu_nmi_ack);
    c_halt: cover property (cpu_halt ##1 !cpu_halt);
endmodule // iacc_top

// >>> verification/iacc_cpu_model.sv
// partner model: cpu core strobes and peripheral request sources
`include "iacc_map.svh"
// ***************************************************************
// cpu and source model
// ***************************************************************
module iacc_cpu_model (
    input wire logic pclk,
    output logic [7:0] src_req,
    output logic nmi_pin_n,
    output logic cpu_instr_done,
    output logic cpu_info_rd,
    output logic cpu_prog_rd,
    output logic cpu_nmi_ack,
    output logic cpu_wait_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle levels; the nmi pin rests high as if pulled up
    initial begin
        src_req = 8'h00;
        nmi_pin_n = 1'b1;
        {cpu_instr_done, cpu_info_rd, cpu_prog_rd, cpu_nmi_ack} = 4'h0;
        cpu_wait_mode = 1'b0;
    end
    // one-cycle request pulse from the chosen sources
    task automatic req(input logic [7:0] m);
        @(posedge pclk);
        src_req <= m;
        @(posedge pclk);
        src_req <= 8'h00;
        #1;
    endtask
    // nmi pin phase, never shorter than the minimum width
    task automatic nmi_phase(input logic lvl);
        @(posedge pclk);
        nmi_pin_n <= lvl;
        repeat (`IACC_NMI_MIN_CYC) @(posedge pclk);
        #1;
    endtask
    // cpu strobe: 0 retire, 1 accept read, 2 program read, 3 nmi ack
    task automatic strobe(input logic [1:0] k);
        @(posedge pclk);
        cpu_instr_done <= (k == 2'd0);
        cpu_info_rd <= (k == 2'd1);
        cpu_prog_rd <= (k == 2'd2);
        cpu_nmi_ack <= (k == 2'd3);
        @(posedge pclk);
        {cpu_instr_done, cpu_info_rd, cpu_prog_rd, cpu_nmi_ack} <= 4'h0;
        #1;
    endtask
    // wait mode is a level held by the cpu
    task automatic set_wait(input logic v);
        @(posedge pclk);
        cpu_wait_mode <= v;
    endtask
endmodule // iacc_cpu_model

// >>> verification/testbench.sv
// self-checking bench for the interrupt accept block
`include "iacc_map.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] src_req, cpu_info_data;
    logic nmi_pin_n, cpu_instr_done, cpu_info_rd, cpu_prog_rd, cpu_nmi_ack, cpu_wait_mode;
    logic cpu_irq_req, cpu_nmi_req, cpu_halt, stop_mode_req, irq;
    logic [15:0] user_stack_pointer, interrupt_stack_pointer;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    // ***************************************************************
    // design and partner
    // ***************************************************************
    iacc_top #(.N(8), .NW(3)) u_iacc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .src_req(src_req), .nmi_pin_n(nmi_pin_n),
        .cpu_instr_done(cpu_instr_done), .cpu_info_rd(cpu_info_rd), .cpu_prog_rd(cpu_prog_rd),
        .cpu_nmi_ack(cpu_nmi_ack), .cpu_wait_mode(cpu_wait_mode), .cpu_irq_req(cpu_irq_req),
        .cpu_nmi_req(cpu_nmi_req), .cpu_info_data(cpu_info_data), .cpu_halt(cpu_halt),
        .stop_mode_req(stop_mode_req), .user_stack_pointer(user_stack_pointer),
        .interrupt_stack_pointer(interrupt_stack_pointer), .irq(irq));
    iacc_cpu_model u_iacc_cpu_model (.pclk(pclk), .src_req(src_req), .nmi_pin_n(nmi_pin_n),
        .cpu_instr_done(cpu_instr_done), .cpu_info_rd(cpu_info_rd), .cpu_prog_rd(cpu_prog_rd),
        .cpu_nmi_ack(cpu_nmi_ack), .cpu_wait_mode(cpu_wait_mode));
    // 40 MHz clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // hang guard: twenty thousand cycles is far beyond the planned run
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_sim();
        end
    end
    // ***************************************************************
    // shared tasks
    // ***************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // apb transfer held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h00000000, q, e);
        chk(q, exp);
    endtask
    // ***************************************************************
    // scenarios
    // ***************************************************************
    task automatic t_reset();
        chk(user_stack_pointer, 32'h00000000);
        chk(interrupt_stack_pointer, 32'h00000000);
        rd(`IACC_OFF_USP, 32'h00000000);
        rd(`IACC_OFF_ISP, 32'h00000000);
        rd(`IACC_OFF_MASK, 32'h00000000);
        rd(`IACC_OFF_EVT, 32'h00000000);
        $display("test reset done");
    endtask
    // requests raised before the first instruction retires stay held back
    task automatic t_first();
        wr(`IACC_OFF_LEVEL, 32'h001B00C0);
        rd(`IACC_OFF_LEVEL, 32'h001B00C0);
        u_iacc_cpu_model.req(8'h04);
        u_iacc_cpu_model.nmi_phase(1'b0);
        chk(cpu_irq_req, 32'h0);
        chk(cpu_nmi_req, 32'h0);
        u_iacc_cpu_model.strobe(2'd0);
        chk(cpu_irq_req, 32'h1);
        chk(cpu_nmi_req, 32'h1);
        $display("test first instruction done");
    endtask
    // pin level readback and stop request lockout, pin starts low
    task automatic t_nmi();
        rd(`IACC_OFF_PORT8, 32'h00000000);
        wr(`IACC_OFF_CM1, 32'h00000001);
        rd(`IACC_OFF_CM1, 32'h00000000);
        chk(stop_mode_req, 32'h0);
        u_iacc_cpu_model.nmi_phase(1'b1);
        rd(`IACC_OFF_PORT8, 32'h00000020);
        wr(`IACC_OFF_CM1, 32'h00000001);
        chk(stop_mode_req, 32'h1);
        wr(`IACC_OFF_CM1, 32'h00000000);
        u_iacc_cpu_model.strobe(2'd3);
        chk(cpu_nmi_req, 32'h0);
        $display("test nmi done");
    endtask
    // sources 2 (level 3), 5 and 6 (level 6 tie) compete
    task automatic t_accept();
        u_iacc_cpu_model.req(8'h60);
        u_iacc_cpu_model.strobe(2'd1);
        chk(cpu_info_data, 32'h65);
        rd(`IACC_OFF_PEND, 32'h00000044);
        u_iacc_cpu_model.strobe(2'd2);
        chk(cpu_info_data, 32'h66);
        rd(`IACC_OFF_PEND, 32'h00000004);
        u_iacc_cpu_model.strobe(2'd1);
        chk(cpu_info_data, 32'h32);
        rd(`IACC_OFF_PEND, 32'h00000000);
        chk(cpu_irq_req, 32'h0);
        $display("test accept done");
    endtask
    // event status, mask, level output and an unmapped access
    task automatic t_evt();
        logic [31:0] q;
        logic e;
        rd(`IACC_OFF_EVT, 32'h00000007);
        chk(irq, 32'h0);
        wr(`IACC_OFF_MASK, 32'h00000002);
        chk(irq, 32'h1);
        wr(`IACC_OFF_EVT, 32'h00000002);
        rd(`IACC_OFF_EVT, 32'h00000005);
        chk(irq, 32'h0);
        apb(1'b0, 8'h20, 32'h00000000, q, e);
        chk(e, 32'h1);
        chk(q, 32'h00000000);
        $display("test events done");
    endtask
    // nmi falling in wait mode halts the cpu until a later interrupt
    task automatic t_wait();
        u_iacc_cpu_model.set_wait(1'b1);
        u_iacc_cpu_model.nmi_phase(1'b0);
        chk(cpu_halt, 32'h1);
        u_iacc_cpu_model.nmi_phase(1'b1);
        u_iacc_cpu_model.strobe(2'd3);
        chk(cpu_halt, 32'h1);
        u_iacc_cpu_model.req(8'h04);
        repeat (2) @(posedge pclk);
        #1;
        chk(cpu_halt, 32'h0);
        u_iacc_cpu_model.set_wait(1'b0);
        u_iacc_cpu_model.strobe(2'd1);
        $display("test wait done");
    endtask
    // software clear of flags, disabled sources, then a reset in mid-run
    // must bring nonzero stack pointers back to zero and re-arm the guard
    task automatic t_rst2();
        wr(`IACC_OFF_USP, 32'h0000A5A4);
        wr(`IACC_OFF_ISP, 32'h00005A58);
        chk(user_stack_pointer, 32'h0000A5A4);
        chk(interrupt_stack_pointer, 32'h00005A58);
        u_iacc_cpu_model.req(8'h81);
        rd(`IACC_OFF_PEND, 32'h00000081);
        wr(`IACC_OFF_PEND, 32'h00000080);
        rd(`IACC_OFF_PEND, 32'h00000001);
        chk(cpu_irq_req, 32'h0);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk(user_stack_pointer, 32'h00000000);
        chk(interrupt_stack_pointer, 32'h00000000);
        rd(`IACC_OFF_PEND, 32'h00000000);
        wr(`IACC_OFF_LEVEL, 32'h000000C0);
        u_iacc_cpu_model.req(8'h04);
        chk(cpu_irq_req, 32'h0);
        u_iacc_cpu_model.strobe(2'd0);
        chk(cpu_irq_req, 32'h1);
        u_iacc_cpu_model.strobe(2'd1);
        chk(cpu_info_data, 32'h32);
        $display("test second reset done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // main sequence: five cycles of reset, then every scenario
    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_first();
        t_nmi();
        t_accept();
        t_evt();
        t_wait();
        t_rst2();
        end_sim();
    end
endmodule // testbench
